//--- src/llc_supervisory_sequencer.sv
// Supervisory sequencer of a resonant converter controller with AHB-Lite registers.
// Assumes comparator flags arrive asynchronously, soft_start comes from hclk logic.
`include "llc_seq_map.svh"
`timescale 1ns/1ps
`default_nettype none

// =============================================================
// Qualification timer
// =============================================================
module qual_timer #(
   parameter int CYCLES = 4
) (
   input  wire logic hclk,
   input  wire logic hresetn,
   input  wire logic flag,
   output logic      done
);
   logic [31:0] cnt_ff;

   // The count restarts whenever the flag drops.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cnt_ff <= 32'h0;
      end else if (!flag) begin
         cnt_ff <= 32'h0;
      end else if (cnt_ff != 32'(CYCLES)) begin
         cnt_ff <= cnt_ff + 32'h1;
      end
   end

   assign done = (cnt_ff == 32'(CYCLES));
endmodule

// =============================================================
// Sequencer top
// =============================================================
module llc_supervisory_sequencer #(
   parameter int BI_CYC      = (`BROWN_IN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
   parameter int BO_CYC      = (`BROWN_OUT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
   parameter int STB_CYC     = (`STB_QUAL_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
   parameter int OLP_CYC     = (`OLP_QUAL_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
   parameter int LONG_CYC    = (`LONG_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
   parameter int SHORT_CYC   = (`SHORT_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
   parameter int STOP_CYC    = (`STOP_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
   parameter int GAP_CYC     = (`PULSE_GAP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
   parameter int STRAP_CYC   = (`STRAP_SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
   parameter int RESTART_CYC = (`OLP_RESTART_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS
) (
   input  wire logic                     hclk,
   input  wire logic                     hresetn,
   input  wire logic                     hsel,
   input  wire logic [31:0]              haddr,
   input  wire logic [1:0]               htrans,
   input  wire logic                     hwrite,
   input  wire logic [2:0]               hsize,
   input  wire logic [31:0]              hwdata,
   input  wire logic                     hready,
   output logic                          hreadyout,
   output logic [31:0]                   hrdata,
   output logic                          hresp,
   input  wire llc_seq_pkg::cmp_flags_t  cmp_in,
   input  wire logic [7:0]               fb_code,
   input  wire logic                     soft_start,
   output logic                          switch_en,
   output logic                          burst_mode,
   output logic                          startup_on,
   output logic                          strap_src_en,
   output llc_seq_pkg::stb_drive_t       stb_drive,
   output logic                          stb_oe,
   output logic                          olp_high_sel,
   output logic [15:0]                   freq_req_khz
);

   // ==========================================================
   // Input synchronisers
   // ==========================================================
   llc_seq_pkg::cmp_flags_t cmp_meta_ff;
   llc_seq_pkg::cmp_flags_t cmp_ff;
   logic [7:0]              fb_meta_ff;
   logic [7:0]              fb_sync_ff, fb_last_ff;
   logic [7:0]              fb_ff;

   // Every comparator flag passes two flops before use.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cmp_meta_ff <= '0;
         cmp_ff      <= '0;
         fb_meta_ff  <= 8'h00;
         fb_sync_ff  <= 8'h00;
         fb_last_ff  <= 8'h00;
         fb_ff       <= 8'h00;
      end else begin
         cmp_meta_ff <= cmp_in;
         cmp_ff      <= cmp_meta_ff;
         fb_meta_ff  <= fb_code;
         fb_sync_ff  <= fb_meta_ff;
         fb_last_ff  <= fb_sync_ff;
         // Use a code only when two samples agree.
         if (fb_sync_ff == fb_last_ff) begin
            fb_ff <= fb_sync_ff;
         end
      end
   end

   // ==========================================================
   // Register interface
   // ==========================================================
   logic [1:0]  ctrl_ff;
   logic [1:0]  evt_ff;
   logic        wr_pend_ff;
   logic [7:0]  wr_addr_ff;
   logic        addr_ok;
   logic [31:0] rd_val;
   logic [31:0] status_val;
   logic [1:0]  evt_set;

   llc_seq_pkg::seq_state_t   state_ff;
   llc_seq_pkg::strap_cfg_t   cfg_ff;
   llc_seq_pkg::pulse_state_t pl_state_ff;
   logic                      fb_run_ff;

   assign addr_ok   = hsel && htrans[1] && hready;
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_ff <= 1'b0;
         wr_addr_ff <= 8'h00;
      end else begin
         wr_pend_ff <= addr_ok && hwrite;
         wr_addr_ff <= haddr[7:0];
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_ff <= `CTRL_RESET;
      end else if (wr_pend_ff && wr_addr_ff == `REG_CTRL_ADDR) begin
         ctrl_ff <= hwdata[1:0];
      end
   end

   // Sticky events; a new event wins over a write-one clear.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         evt_ff <= 2'h0;
      end else if (wr_pend_ff && wr_addr_ff == `REG_STATUS_ADDR) begin
         evt_ff <= (evt_ff & ~hwdata[`EVT_OLP_BIT:`EVT_BO_BIT]) | evt_set;
      end else begin
         evt_ff <= evt_ff | evt_set;
      end
   end

   always_comb begin
      status_val = 32'h0;
      status_val[2:0] = state_ff;
      status_val[3] = cfg_ff.ext_standby;
      status_val[4] = cfg_ff.olp_high;
      status_val[5] = burst_mode;
      status_val[6] = fb_run_ff;
      status_val[7] = (pl_state_ff != llc_seq_pkg::PL_IDLE);
      status_val[`EVT_OLP_BIT:`EVT_BO_BIT] = evt_ff;
   end

   always_comb begin
      case (haddr[7:0])
         `REG_CTRL_ADDR:   rd_val = {30'h0, ctrl_ff};
         `REG_STATUS_ADDR: rd_val = status_val;
         `REG_FREQ_ADDR:   rd_val = {16'h0, freq_req_khz};
         default:          rd_val = 32'h0;
      endcase
   end

   // Read data is captured in the address phase so it stands in the data phase.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h0;
      end else if (addr_ok && !hwrite) begin
         hrdata <= rd_val;
      end
   end

   // ==========================================================
   // Qualification timers
   // ==========================================================
   logic bi_done;
   logic bo_done;
   logic olp_done;
   logic stb_done;
   logic olp_flag;
   logic stb_req_ff;

   // Overload is only watched while running and outside soft start.
   assign olp_flag = cmp_ff.fb_overload && !soft_start && (state_ff == llc_seq_pkg::ST_RUN);

   qual_timer #(.CYCLES(BI_CYC)) u_bi (
      .hclk    (hclk),
      .hresetn (hresetn),
      .flag    (cmp_ff.vh_brown_in),
      .done    (bi_done)
   );
   qual_timer #(.CYCLES(BO_CYC)) u_bo (
      .hclk    (hclk),
      .hresetn (hresetn),
      .flag    (cmp_ff.vh_brown_out),
      .done    (bo_done)
   );
   qual_timer #(.CYCLES(OLP_CYC)) u_olp (
      .hclk    (hclk),
      .hresetn (hresetn),
      .flag    (olp_flag),
      .done    (olp_done)
   );
   qual_timer #(.CYCLES(STB_CYC)) u_stb (
      .hclk    (hclk),
      .hresetn (hresetn),
      .flag    (stb_req_ff),
      .done    (stb_done)
   );

   // ==========================================================
   // Main sequence
   // ==========================================================
   logic [31:0] seq_cnt_ff;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_ff   <= llc_seq_pkg::ST_POR;
         seq_cnt_ff <= 32'h0;
      end else begin
         seq_cnt_ff <= seq_cnt_ff + 32'h1;
         case (state_ff)
            llc_seq_pkg::ST_POR: begin
               seq_cnt_ff <= 32'h0;
               if (cmp_ff.vcc_upper) begin
                  state_ff <= llc_seq_pkg::ST_STRAP;
               end
            end
            llc_seq_pkg::ST_STRAP: begin
               if (seq_cnt_ff == 32'(STRAP_CYC - 1)) begin
                  state_ff <= llc_seq_pkg::ST_WAIT_BI;
               end
            end
            llc_seq_pkg::ST_WAIT_BI: begin
               if (bi_done) begin
                  state_ff <= llc_seq_pkg::ST_RUN;
               end
            end
            llc_seq_pkg::ST_RUN: begin
               seq_cnt_ff <= 32'h0;
               if (bo_done) begin
                  state_ff <= llc_seq_pkg::ST_BROWNOUT;
               end else if (olp_done) begin
                  state_ff <= llc_seq_pkg::ST_OLP_OFF;
               end
            end
            llc_seq_pkg::ST_BROWNOUT: begin
               if (cmp_ff.vh_brown_in) begin
                  state_ff <= llc_seq_pkg::ST_RUN;
               end
            end
            llc_seq_pkg::ST_OLP_OFF: begin
               // Restart through brown-in so a lasting overload cycles.
               if (seq_cnt_ff == 32'(RESTART_CYC - 1)) begin
                  state_ff <= llc_seq_pkg::ST_WAIT_BI;
               end
            end
            default: state_ff <= llc_seq_pkg::ST_POR;
         endcase
      end
   end

   assign evt_set = {olp_done && state_ff == llc_seq_pkg::ST_RUN,
                     bo_done && state_ff == llc_seq_pkg::ST_RUN};

   // Strap current flows only during the settle window; decode at its end.
   assign strap_src_en = (state_ff == llc_seq_pkg::ST_STRAP);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cfg_ff <= '0;
      end else if (state_ff == llc_seq_pkg::ST_STRAP && seq_cnt_ff == 32'(STRAP_CYC - 1)) begin
         cfg_ff.ext_standby <= !cmp_ff.strap_above_a;
         cfg_ff.olp_high    <= cmp_ff.strap_above_b;
      end
   end
   assign olp_high_sel = cfg_ff.olp_high;

   // Start-up path hysteresis holds the supply between the two levels.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         startup_on <= 1'b1;
      end else if (state_ff == llc_seq_pkg::ST_RUN) begin
         startup_on <= 1'b0;
      end else if (state_ff == llc_seq_pkg::ST_POR) begin
         startup_on <= 1'b1;
      end else if (cmp_ff.vcc_lower) begin
         startup_on <= 1'b1;
      end else if (cmp_ff.vcc_upper) begin
         startup_on <= 1'b0;
      end
   end

   // Feedback start/stop hysteresis.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         fb_run_ff <= 1'b0;
      end else if (state_ff != llc_seq_pkg::ST_RUN || cmp_ff.fb_stop) begin
         fb_run_ff <= 1'b0;
      end else if (cmp_ff.fb_start) begin
         fb_run_ff <= 1'b1;
      end
   end

   assign switch_en = (state_ff == llc_seq_pkg::ST_RUN) && fb_run_ff && ctrl_ff[`CTRL_SW_EN_BIT];

   // ==========================================================
   // Frequency request
   // ==========================================================
   logic [15:0] fb_diff;
   logic [15:0] span;

   assign span = {8'h0, `FB_CODE_TOP - `FB_CODE_START};
   always_comb begin
      if (fb_ff <= `FB_CODE_START) begin
         fb_diff = 16'h0;
      end else if (fb_ff >= `FB_CODE_TOP) begin
         fb_diff = span;
      end else begin
         fb_diff = {8'h0, fb_ff - `FB_CODE_START};
      end
   end

   // Linear fall from maximum to minimum across the feedback span.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         freq_req_khz <= `FREQ_MAX_KHZ;
      end else begin
         freq_req_khz <= `FREQ_MAX_KHZ - 16'((fb_diff * (`FREQ_MAX_KHZ - `FREQ_MIN_KHZ)) / span);
      end
   end

   // ==========================================================
   // Standby selection
   // ==========================================================
   logic        ext_burst_ff;
   logic        auto_burst_ff;
   logic        want_burst;
   logic        want_stop;
   logic        stop_sent_ff;
   logic [1:0]  pl_left_ff;
   logic [31:0] pl_cnt_ff;
   logic [31:0] pl_len_ff;

   // External level with detection hysteresis.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         stb_req_ff <= 1'b0;
      end else if (!cfg_ff.ext_standby || cmp_ff.stb_low) begin
         stb_req_ff <= 1'b0;
      end else if (cmp_ff.stb_high) begin
         stb_req_ff <= 1'b1;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ext_burst_ff <= 1'b0;
      end else begin
         ext_burst_ff <= stb_done;
      end
   end

   assign burst_mode = cfg_ff.ext_standby ? ext_burst_ff : auto_burst_ff;

   // Auto standby drives the pin; external standby leaves it as input.
   assign stb_oe = !cfg_ff.ext_standby && state_ff != llc_seq_pkg::ST_POR
                   && state_ff != llc_seq_pkg::ST_STRAP;

   // Mode follows averaged power; stop is a software command.
   assign want_burst = cmp_ff.power_light;
   assign want_stop  = ctrl_ff[`CTRL_PFC_STOP_BIT];

   // ==========================================================
   // Companion mode signalling
   // ==========================================================
   // A new command is only considered in idle, so trains never overlap.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pl_state_ff   <= llc_seq_pkg::PL_IDLE;
         pl_cnt_ff     <= 32'h0;
         pl_len_ff     <= 32'h0;
         pl_left_ff    <= 2'h0;
         auto_burst_ff <= 1'b0;
         stop_sent_ff  <= 1'b0;
      end else begin
         pl_cnt_ff <= pl_cnt_ff + 32'h1;
         case (pl_state_ff)
            llc_seq_pkg::PL_IDLE: begin
               pl_cnt_ff <= 32'h0;
               if (!stb_oe) begin
                  stop_sent_ff <= 1'b0;
               end else if (want_stop) begin
                  pl_state_ff <= llc_seq_pkg::PL_STOP;
               end else if (want_burst != auto_burst_ff || stop_sent_ff) begin
                  // Long pulses toward burst, short toward normal.
                  pl_len_ff   <= want_burst ? 32'(LONG_CYC) : 32'(SHORT_CYC);
                  pl_left_ff  <= cmp_ff.line_high ? 2'h1 : 2'h2;
                  pl_state_ff <= llc_seq_pkg::PL_PULSE;
                  auto_burst_ff <= want_burst;
                  stop_sent_ff  <= 1'b0;
               end
            end
            llc_seq_pkg::PL_PULSE: begin
               if (pl_cnt_ff == pl_len_ff - 32'h1) begin
                  pl_cnt_ff   <= 32'h0;
                  pl_left_ff  <= pl_left_ff - 2'h1;
                  pl_state_ff <= llc_seq_pkg::PL_GAP;
               end
            end
            llc_seq_pkg::PL_GAP: begin
               // Fixed low interval after every pulse.
               if (pl_cnt_ff == 32'(GAP_CYC - 1)) begin
                  pl_cnt_ff   <= 32'h0;
                  pl_state_ff <= (pl_left_ff == 2'h0) ? llc_seq_pkg::PL_IDLE
                                                      : llc_seq_pkg::PL_PULSE;
               end
            end
            llc_seq_pkg::PL_STOP: begin
               stop_sent_ff <= 1'b1;
               // Held continuously, never shorter than the stop width.
               if (!want_stop && pl_cnt_ff >= 32'(STOP_CYC - 1)) begin
                  pl_cnt_ff   <= 32'h0;
                  pl_state_ff <= llc_seq_pkg::PL_GAP;
               end
            end
            default: pl_state_ff <= llc_seq_pkg::PL_IDLE;
         endcase
      end
   end

   always_comb begin
      case (pl_state_ff)
         llc_seq_pkg::PL_PULSE: stb_drive = llc_seq_pkg::DRV_MID;
         llc_seq_pkg::PL_STOP:  stb_drive = llc_seq_pkg::DRV_HIGH;
         default:               stb_drive = llc_seq_pkg::DRV_LOW;
      endcase
   end

endmodule
`default_nettype wire

//--- src/llc_seq_map.svh
// Offsets, field positions, reset values and timing figures of the sequencer.
// Assumes a 250 MHz hclk; times are given in ns and converted in the module.
`ifndef LLC_SEQ_MAP_SVH
`define LLC_SEQ_MAP_SVH

`define CLK_PERIOD_NS    4
`define BROWN_IN_NS      160000
`define BROWN_OUT_NS     47000000
`define STB_QUAL_NS      108000000
`define OLP_QUAL_NS      76800000
`define LONG_PULSE_NS    6000000
`define SHORT_PULSE_NS   500000
`define STOP_PULSE_NS    250000
`define PULSE_GAP_NS     4000000
`define STRAP_SETTLE_NS  1000000
`define OLP_RESTART_NS   1000000000

`define FB_CODE_START    8'h24
`define FB_CODE_TOP      8'h9A
`define FREQ_MAX_KHZ     16'h010E
`define FREQ_MIN_KHZ     16'h0019

`define REG_CTRL_ADDR    8'h00
`define REG_STATUS_ADDR  8'h04
`define REG_FREQ_ADDR    8'h08
`define CTRL_RESET       2'h1
`define CTRL_SW_EN_BIT   0
`define CTRL_PFC_STOP_BIT 1
`define EVT_BO_BIT       8
`define EVT_OLP_BIT      9

`endif

//--- src/llc_seq_pkg.sv
// Types shared by the supervisory sequencer.
// Assumes the constants of llc_seq_map.svh for figures and offsets.
package llc_seq_pkg;

   typedef enum logic [2:0] {
      ST_POR, ST_STRAP, ST_WAIT_BI, ST_RUN, ST_BROWNOUT, ST_OLP_OFF
   } seq_state_t;

   typedef enum logic [1:0] {PL_IDLE, PL_PULSE, PL_GAP, PL_STOP} pulse_state_t;

   typedef enum logic [1:0] {DRV_LOW, DRV_MID, DRV_HIGH} stb_drive_t;

   typedef struct packed {
      logic ext_standby;
      logic olp_high;
   } strap_cfg_t;

   // Comparator flags, all asynchronous to hclk.
   typedef struct packed {
      logic vh_brown_in;
      logic vh_brown_out;
      logic vcc_upper;
      logic vcc_lower;
      logic fb_start;
      logic fb_stop;
      logic fb_overload;
      logic stb_high;
      logic stb_low;
      logic strap_above_a;
      logic strap_above_b;
      logic power_light;
      logic line_high;
   } cmp_flags_t;

endpackage

//--- verification/llc_pfc_partner.sv
// Companion controller model that decodes the mode pulses on the standby link.
// Assumes the sequencer drives the pin only while stb_oe is high.
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Companion pulse decoder
// ==========================================================
module llc_pfc_partner #(
   parameter int LONG_CYC = 12
) (
   input  wire logic                    hclk,
   input  wire llc_seq_pkg::stb_drive_t stb_drive,
   input  wire logic                    stb_oe,
   output logic [7:0]                   n_long,
   output logic [7:0]                   n_short
);
   int width = 0;
   initial begin
      n_long = 8'h00;
      n_short = 8'h00;
   end
   // A pulse is judged only at its end, so a cut-short long pulse counts as short.
   always @(posedge hclk) begin
      if (stb_oe && stb_drive == llc_seq_pkg::DRV_MID) begin
         width <= width + 1;
      end else begin
         if (width >= LONG_CYC) n_long <= n_long + 8'h01;
         else if (width > 0) n_short <= n_short + 8'h01;
         width <= 0;
      end
   end
endmodule
`default_nettype wire

//--- verification/llc_seq_asserts.sv
// Port checker of the supervisory sequencer.
// Assumes the shortened counts of the bench: gap 5 cycles, stop hold 4 cycles.
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Checker
// ==========================================================
module llc_seq_asserts #(
   parameter int BI_CYC    = 8,
   parameter int LONG_CYC  = 12,
   parameter int SHORT_CYC = 6
) (
   input wire logic                    hclk,
   input wire logic                    hresetn,
   input wire llc_seq_pkg::cmp_flags_t cmp_in,
   input wire logic                    switch_en,
   input wire logic                    startup_on,
   input wire logic                    strap_src_en,
   input wire llc_seq_pkg::stb_drive_t stb_drive,
   input wire logic                    stb_oe,
   input wire logic                    olp_high_sel,
   input wire logic [15:0]             freq_req_khz
);
   int   bi_ff;
   int   mid_ff;
   logic ran_ff;
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   // Counts use raw flags; the design's synchronisers only make it later.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         bi_ff <= 0;
         mid_ff <= 0;
         ran_ff <= 1'b0;
      end else begin
         bi_ff <= cmp_in.vh_brown_in ? bi_ff + 1 : 0;
         mid_ff <= (stb_drive == llc_seq_pkg::DRV_MID) ? mid_ff + 1 : 0;
         ran_ff <= ran_ff | switch_en;
      end
   end
   a_brown_in_wait: assert property ($rose(switch_en) && !ran_ff |-> bi_ff >= BI_CYC)
      else $error("switching began before brown-in was held");
   a_startup_run: assert property (switch_en [*2] |-> !startup_on)
      else $error("start-up path on while switching");
   a_strap_decode: assert property ($fell(strap_src_en) |-> ##[0:2] olp_high_sel == cmp_in.strap_above_b)
      else $error("strap result not latched");
   a_pin_owner: assert property (stb_drive != llc_seq_pkg::DRV_LOW |-> stb_oe)
      else $error("link pin driven while not owned");
   a_pulse_width: assert property ($fell(stb_drive == llc_seq_pkg::DRV_MID) |->
      mid_ff == LONG_CYC || mid_ff == SHORT_CYC)
      else $error("mode pulse of wrong width");
   a_pulse_gap: assert property ($fell(stb_drive == llc_seq_pkg::DRV_MID) |->
      (stb_drive == llc_seq_pkg::DRV_LOW) [*5])
      else $error("gap after mode pulse too short");
   a_stop_hold: assert property ($rose(stb_drive == llc_seq_pkg::DRV_HIGH) |->
      (stb_drive == llc_seq_pkg::DRV_HIGH) [*4])
      else $error("stop level too short");
   a_freq_range: assert property (freq_req_khz >= 16'h0019 && freq_req_khz <= 16'h010E)
      else $error("frequency request out of range");
endmodule
bind llc_supervisory_sequencer llc_seq_asserts #(.BI_CYC(BI_CYC), .LONG_CYC(LONG_CYC), .SHORT_CYC(SHORT_CYC))
   llc_seq_asserts_i (.hclk(hclk), .hresetn(hresetn), .cmp_in(cmp_in), .switch_en(switch_en),
   .startup_on(startup_on), .strap_src_en(strap_src_en), .stb_drive(stb_drive), .stb_oe(stb_oe),
   .olp_high_sel(olp_high_sel), .freq_req_khz(freq_req_khz));
`default_nettype wire

//--- verification/llc_supervisory_sequencer_test.sv
// Self-checking bench of the supervisory sequencer in auto standby, then in external standby after a second reset.
// Assumes shortened counts; all inputs change by non-blocking assignment at rising edges.
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Bench
// ==========================================================
module llc_supervisory_sequencer_test;
   localparam int BI = 8, BO = 12, OVL = 14, LNG = 12, SHT = 6, GAP = 5, RST = 20;
   logic                    hclk;
   logic                    hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, soft_start = 1'b0;
   logic [31:0]             haddr = 32'h0, hwdata = 32'h0, hrdata, rd, rnd = 32'h0000FD94;
   logic [1:0]              htrans = 2'h0;
   logic [7:0]              fb_code = 8'h00, n_long, n_short;
   logic [7:0]              corner [4] = '{8'h00, 8'h24, 8'h9A, 8'hFF};
   logic                    hreadyout, hresp, switch_en, burst_mode, startup_on, strap_src_en, stb_oe;
   logic                    olp_high_sel;
   logic [15:0]             freq_req_khz;
   llc_seq_pkg::cmp_flags_t cmp = '0;
   llc_seq_pkg::stb_drive_t stb_drive;
   int                      n_fail = 0, samples_checked = 0;
   llc_supervisory_sequencer #(.BI_CYC(BI), .BO_CYC(BO), .STB_CYC(10), .OLP_CYC(OVL), .LONG_CYC(LNG),
      .SHORT_CYC(SHT), .STOP_CYC(4), .GAP_CYC(GAP), .STRAP_CYC(4), .RESTART_CYC(RST))
      llc_supervisory_sequencer_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .cmp_in(cmp), .fb_code(fb_code),
      .soft_start(soft_start), .switch_en(switch_en), .burst_mode(burst_mode), .startup_on(startup_on),
      .strap_src_en(strap_src_en), .stb_drive(stb_drive), .stb_oe(stb_oe), .olp_high_sel(olp_high_sel),
      .freq_req_khz(freq_req_khz));
   llc_pfc_partner #(.LONG_CYC(LNG)) llc_pfc_partner_i (.hclk(hclk), .stb_drive(stb_drive),
      .stb_oe(stb_oe), .n_long(n_long), .n_short(n_short));
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic logic [15:0] fexp(input logic [7:0] c);
      int d;
      d = (c < 8'h24) ? 0 : ((c > 8'h9A) ? 118 : int'(c) - 36);
      return 16'(270 - d * 245 / 118);
   endfunction
   task chk(input logic [31:0] seen, input logic [31:0] exp, input string nm);
      samples_checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
      end
   endtask
   task cyc(input int n);
      repeat (n) @(posedge hclk);
   endtask
   task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= a;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
      hsel <= 1'b0;
   endtask
   task results;
      if (n_fail == 0 && samples_checked > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   initial begin
      hclk = 1'b0;
      forever #2 hclk = ~hclk;
   end
   // The whole sequence needs about four hundred cycles.
   initial begin
      #40000;
      n_fail++;
      results;
   end
   initial begin
      cyc(3);
      hresetn <= 1'b1;
      cyc(1);
      chk(freq_req_khz, 16'h010E, "freq_req_khz");
      chk(switch_en, 1'b0, "switch_en");
      cmp.strap_above_a <= 1'b1;
      cmp.strap_above_b <= 1'b1;
      cmp.vcc_upper <= 1'b1;
      cyc(14);
      chk(olp_high_sel, 1'b1, "olp_high_sel");
      chk(stb_oe, 1'b1, "stb_oe");
      cmp.vh_brown_in <= 1'b1;
      cmp.fb_start <= 1'b1;
      cyc(BI - 2);
      chk(switch_en, 1'b0, "switch_en");
      cyc(10);
      chk(switch_en, 1'b1, "switch_en");
      bus(1'b0, 32'h4, 32'h0);
      chk(rd[2:0], 3'h3, "state");
      for (int i = 0; i < 12; i++) begin
         rnd = lfsr(rnd);
         fb_code <= (i < 4) ? corner[i] : rnd[7:0];
         cyc(6);
         chk(freq_req_khz, fexp(fb_code), "freq_req_khz");
      end
      cmp.power_light <= 1'b1;
      cyc(2 * (LNG + GAP) + 10);
      chk(n_long, 8'h02, "long pulses");
      chk(burst_mode, 1'b1, "burst_mode");
      cmp.power_light <= 1'b0;
      cmp.line_high <= 1'b1;
      cyc(SHT + GAP + 10);
      chk(n_short, 8'h01, "short pulses");
      chk(burst_mode, 1'b0, "burst_mode");
      bus(1'b1, 32'h0, 32'h3);
      cyc(3);
      chk(stb_drive, llc_seq_pkg::DRV_HIGH, "stb_drive");
      bus(1'b1, 32'h0, 32'h1);
      cyc(4 + 3 * GAP + 2 * LNG + 10);
      chk(stb_drive, llc_seq_pkg::DRV_LOW, "stb_drive");
      soft_start <= 1'b1;
      cmp.fb_overload <= 1'b1;
      cyc(OVL + 10);
      chk(switch_en, 1'b1, "switch_en");
      soft_start <= 1'b0;
      cyc(OVL + 6);
      chk(switch_en, 1'b0, "switch_en");
      bus(1'b0, 32'h4, 32'h0);
      chk(rd[9], 1'b1, "overload event");
      cmp.fb_overload <= 1'b0;
      cyc(RST + BI + 12);
      chk(switch_en, 1'b1, "switch_en");
      cmp.vh_brown_in <= 1'b0;
      cmp.vh_brown_out <= 1'b1;
      cyc(BO + 6);
      chk(switch_en, 1'b0, "switch_en");
      bus(1'b0, 32'h4, 32'h0);
      chk(rd[8], 1'b1, "brown-out event");
      cmp.vcc_upper <= 1'b0;
      cmp.vcc_lower <= 1'b1;
      cyc(5);
      chk(startup_on, 1'b1, "startup_on");
      cmp.vcc_lower <= 1'b0;
      cmp.vcc_upper <= 1'b1;
      cyc(5);
      chk(startup_on, 1'b0, "startup_on");
      cmp.vh_brown_in <= 1'b1;
      cmp.vh_brown_out <= 1'b0;
      cyc(6);
      chk(switch_en, 1'b1, "switch_en");
      cmp.fb_start <= 1'b0;
      cmp.fb_stop <= 1'b1;
      cyc(5);
      chk(switch_en, 1'b0, "switch_en");
      bus(1'b0, 32'h40, 32'h0);
      chk(rd, 32'h0, "unmapped read");
      hresetn <= 1'b0;
      cmp.strap_above_a <= 1'b0;
      cmp.stb_high <= 1'b1;
      cyc(2);
      hresetn <= 1'b1;
      cyc(5);
      chk(strap_src_en, 1'b1, "strap_src_en");
      cyc(10);
      chk(burst_mode, 1'b0, "burst_mode");
      cyc(15);
      chk(burst_mode, 1'b1, "burst_mode");
      cmp.stb_high <= 1'b0;
      cmp.stb_low <= 1'b1;
      cyc(7);
      chk(burst_mode, 1'b0, "burst_mode");
      results;
   end
endmodule
`default_nettype wire
